// File: inc/spirq_pkg.sv
// package for the serial port interrupt output router
package spirq_pkg;
  localparam int SPIRQ_PORTS = 2;
  // interrupt enable register bit positions
  localparam int SPIRQ_IE_RXDATA = 0;
  localparam int SPIRQ_IE_THRE = 1;
  localparam int SPIRQ_IE_RXERR = 2;
  localparam int SPIRQ_IE_MODEM = 3;
  localparam int SPIRQ_IER_W = 4;
  // modem control register output gate bit
  localparam int SPIRQ_MCR_GATE = 3;
  localparam int SPIRQ_MCR_W = 5;
  // com designation encodings
  localparam logic [1:0] SPIRQ_COM1 = 2'h0;
  localparam logic [1:0] SPIRQ_COM2 = 2'h1;
  localparam logic [1:0] SPIRQ_COM3 = 2'h2;
  localparam logic [1:0] SPIRQ_COM4 = 2'h3;
  // synchroniser depth for pin inputs
  localparam int SPIRQ_SYNC = 3;
endpackage

// File: logic/spirq_out.sv
// serial port interrupt routing onto irq3 and irq4 lines
`timescale 1ns/100ps
// Functional notes
// - serial interrupt lines are active high; high means pending, low means idle.
// - a port designated com2 or com4 drives its interrupt onto irq3.
// - a port designated com1 or com3 drives its interrupt onto irq4.
// - interrupt asserts only when its source is enabled and the output gate bit is set.
// - sources are receiver error, data available, holding register empty, modem status.
// - line drops low after servicing, after disable, or after master reset.
// - a line floats when no port routed onto it has its modem control output gate bit set.
module spirq_out import spirq_pkg::*; (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // master reset pin, asynchronous to core_clk
  input wire logic master_reset_input,
  // per port configuration from the uart cores
  input wire logic [SPIRQ_PORTS-1:0][1:0] com_sel,
  input wire logic [SPIRQ_PORTS-1:0][SPIRQ_IER_W-1:0] interrupt_enable_reg,
  input wire logic [SPIRQ_PORTS-1:0][SPIRQ_MCR_W-1:0] modem_control_reg,
  // per port pending conditions, cleared by the uart when serviced
  input wire logic [SPIRQ_PORTS-1:0] rx_error,
  input wire logic [SPIRQ_PORTS-1:0] rx_data_avail,
  input wire logic [SPIRQ_PORTS-1:0] thr_empty,
  input wire logic [SPIRQ_PORTS-1:0] modem_status_flag,
  // isa interrupt lines, enable active low
  output logic irq3_out,
  output logic irq3_oe_n,
  output logic irq4_out,
  output logic irq4_oe_n
);

  // master reset synchroniser; stage 0 feeds only stage 1
  // the pin is slow and asynchronous, so three stages trade latency for a clean level
  logic [SPIRQ_SYNC-1:0] mr_sync;
  logic mr_active;
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      mr_sync <= '0;
    end else begin
      mr_sync <= {mr_sync[SPIRQ_SYNC-2:0], master_reset_input};
    end
  end

  // change counts once stages one and two agree
  logic next_mr_active;
  assign next_mr_active = (mr_sync[1] == mr_sync[2]) ? mr_sync[2] : mr_active;
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      mr_active <= 1'b0;
    end else begin
      mr_active <= next_mr_active;
    end
  end

  // per port request and routing decode
  // designations are levels; changing one simply reroutes the request on the next edge
  logic [SPIRQ_PORTS-1:0] gate;
  logic [SPIRQ_PORTS-1:0] req;
  logic [SPIRQ_PORTS-1:0] to_irq3;
  logic [SPIRQ_PORTS-1:0] to_irq4;
  genvar p;
  generate
    for (p = 0; p < SPIRQ_PORTS; p++) begin : g_port
      assign gate[p] = modem_control_reg[p][SPIRQ_MCR_GATE];
      // any enabled condition, gated; dropping an enable or a condition releases it
      assign req[p] = gate[p] & ~mr_active & (
        (interrupt_enable_reg[p][SPIRQ_IE_RXERR] & rx_error[p]) |
        (interrupt_enable_reg[p][SPIRQ_IE_RXDATA] & rx_data_avail[p]) |
        (interrupt_enable_reg[p][SPIRQ_IE_THRE] & thr_empty[p]) |
        (interrupt_enable_reg[p][SPIRQ_IE_MODEM] & modem_status_flag[p]));
      assign to_irq3[p] = (com_sel[p] == SPIRQ_COM2) | (com_sel[p] == SPIRQ_COM4);
      assign to_irq4[p] = (com_sel[p] == SPIRQ_COM1) | (com_sel[p] == SPIRQ_COM3);
    end
  endgenerate

  // line values; if both ports pick one line, they are or-ed rather than fighting
  // limitation: software cannot tell from the line alone which port asked
  logic next_irq3;
  logic next_irq4;
  logic next_irq3_en;
  logic next_irq4_en;
  assign next_irq3 = |(req & to_irq3);
  assign next_irq4 = |(req & to_irq4);
  assign next_irq3_en = |(gate & to_irq3);
  assign next_irq4_en = |(gate & to_irq4);

  // registered outputs; reset leaves lines floating and low
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      irq3_out <= 1'b0;
      irq4_out <= 1'b0;
      irq3_oe_n <= 1'b1;
      irq4_oe_n <= 1'b1;
    end else begin
      irq3_out <= next_irq3;
      irq4_out <= next_irq4;
      irq3_oe_n <= ~next_irq3_en;
      irq4_oe_n <= ~next_irq4_en;
    end
  end

  // checks; they read raw inputs where they can, so a broken decode still trips them
  // routing: an enabled, gated port 0 condition lands on the line its designation picks
  chk_irq3_route: assert property (@(posedge core_clk) disable iff (rst)
    ((com_sel[0] == SPIRQ_COM2 || com_sel[0] == SPIRQ_COM4) && modem_control_reg[0][SPIRQ_MCR_GATE]
     && !mr_active && (|(interrupt_enable_reg[0]
     & {modem_status_flag[0], rx_error[0], thr_empty[0], rx_data_avail[0]})))
    |=> irq3_out && !irq3_oe_n)
    else $error("port 0 interrupt missing on irq3");

  chk_irq4_route: assert property (@(posedge core_clk) disable iff (rst)
    ((com_sel[0] == SPIRQ_COM1 || com_sel[0] == SPIRQ_COM3) && modem_control_reg[0][SPIRQ_MCR_GATE]
     && !mr_active && (|(interrupt_enable_reg[0]
     & {modem_status_flag[0], rx_error[0], thr_empty[0], rx_data_avail[0]})))
    |=> irq4_out && !irq4_oe_n)
    else $error("port 0 interrupt missing on irq4");

  // irq4 must float with no gated port on it, and both lines must float when no port is gated at all
  chk_float_no_gate: assert property (@(posedge core_clk) disable iff (rst)
    !(|gate) |=> irq3_oe_n && irq4_oe_n)
    else $error("line driven without gate");

  chk_irq4_float: assert property (@(posedge core_clk) disable iff (rst)
    !(|(gate & to_irq4)) |=> irq4_oe_n)
    else $error("irq4 driven without a gated port");

  // and a line with a gated port on it must be driven
  chk_irq3_drives: assert property (@(posedge core_clk) disable iff (rst)
    (|(gate & to_irq3)) |=> !irq3_oe_n)
    else $error("irq3 floating with a gated port");

  chk_irq4_drives: assert property (@(posedge core_clk) disable iff (rst)
    (|(gate & to_irq4)) |=> !irq4_oe_n)
    else $error("irq4 floating with a gated port");

  // a floating line also rests low, so a stray enable cannot show a false request
  chk_low_when_float: assert property (@(posedge core_clk) disable iff (rst)
    irq3_oe_n |-> !irq3_out)
    else $error("irq3 high while floating");

  chk_irq4_low_float: assert property (@(posedge core_clk) disable iff (rst)
    irq4_oe_n |-> !irq4_out)
    else $error("irq4 high while floating");

  // no gate anywhere means no request anywhere
  chk_idle_no_gate: assert property (@(posedge core_clk) disable iff (rst)
    !(|gate) |=> !irq3_out && !irq4_out)
    else $error("line high without any gate");

  // master reset, disable and servicing all pull the lines low
  chk_reset_clears: assert property (@(posedge core_clk) disable iff (rst)
    mr_active |=> !irq3_out && !irq4_out)
    else $error("line high during master reset");

  chk_disable_drops: assert property (@(posedge core_clk) disable iff (rst)
    (interrupt_enable_reg[0] == '0 && interrupt_enable_reg[1] == '0) |=> !irq3_out && !irq4_out)
    else $error("line high with all sources disabled");

  chk_all_serviced: assert property (@(posedge core_clk) disable iff (rst)
    (rx_error == '0 && rx_data_avail == '0 && thr_empty == '0
     && modem_status_flag == '0)
    |=> !irq3_out && !irq4_out)
    else $error("line high with nothing pending");

  // synchroniser: agreement of the last two stages moves mr_active, disagreement holds it
  chk_mr_sync: assert property (@(posedge core_clk) disable iff (rst)
    (mr_sync[2] && mr_sync[1]) |=> mr_active)
    else $error("master reset not taken");

  chk_mr_release: assert property (@(posedge core_clk) disable iff (rst)
    (!mr_sync[2] && !mr_sync[1]) |=> !mr_active)
    else $error("master reset not released");

  chk_mr_hold: assert property (@(posedge core_clk) disable iff (rst)
    (mr_sync[2] != mr_sync[1]) |=> $stable(mr_active))
    else $error("master reset moved on a disagreement");

  // port 0 data available on a com1 or com3 designation
  chk_rx_asserts: assert property (@(posedge core_clk) disable iff (rst)
    (gate[0] && !mr_active && interrupt_enable_reg[0][SPIRQ_IE_RXDATA] && rx_data_avail[0]
     && to_irq4[0])
    |=> irq4_out && !irq4_oe_n)
    else $error("port 0 data interrupt missing");

  // per port source checks; each enabled condition alone must raise its routed line
  genvar q;
  generate
    for (q = 0; q < SPIRQ_PORTS; q++) begin : g_chk
      // receiver error alone, enabled and gated
      chk_src_rxerr: assert property (@(posedge core_clk) disable iff (rst)
        (modem_control_reg[q][SPIRQ_MCR_GATE] && !mr_active
         && interrupt_enable_reg[q][SPIRQ_IE_RXERR] && rx_error[q])
        |=> ($past(to_irq3[q]) ? irq3_out : irq4_out))
        else $error("receiver error interrupt missing");

      // received data alone, enabled and gated
      chk_src_rxdata: assert property (@(posedge core_clk) disable iff (rst)
        (modem_control_reg[q][SPIRQ_MCR_GATE] && !mr_active
         && interrupt_enable_reg[q][SPIRQ_IE_RXDATA] && rx_data_avail[q])
        |=> ($past(to_irq3[q]) ? irq3_out : irq4_out))
        else $error("data available interrupt missing");

      // holding register empty alone, enabled and gated
      chk_src_thre: assert property (@(posedge core_clk) disable iff (rst)
        (modem_control_reg[q][SPIRQ_MCR_GATE] && !mr_active
         && interrupt_enable_reg[q][SPIRQ_IE_THRE] && thr_empty[q])
        |=> ($past(to_irq3[q]) ? irq3_out : irq4_out))
        else $error("holding register empty interrupt missing");

      // modem status alone, enabled and gated
      chk_src_modem: assert property (@(posedge core_clk) disable iff (rst)
        (modem_control_reg[q][SPIRQ_MCR_GATE] && !mr_active
         && interrupt_enable_reg[q][SPIRQ_IE_MODEM] && modem_status_flag[q])
        |=> ($past(to_irq3[q]) ? irq3_out : irq4_out))
        else $error("modem status interrupt missing");

      // pending conditions that are all masked leave the line low when the other port is ungated
      chk_port_masked: assert property (@(posedge core_clk) disable iff (rst)
        (modem_control_reg[q][SPIRQ_MCR_GATE] && !modem_control_reg[SPIRQ_PORTS-1-q][SPIRQ_MCR_GATE]
         && (interrupt_enable_reg[q] & {modem_status_flag[q], rx_error[q], thr_empty[q], rx_data_avail[q]}) == '0)
        |=> !($past(to_irq3[q]) ? irq3_out : irq4_out))
        else $error("masked condition raised the line");
    end
  endgenerate
endmodule

// File: tb/serial_port_interrupt_output_bench.sv
// testbench for the serial port interrupt router
`timescale 1ns/100ps
module serial_port_interrupt_output_bench import spirq_pkg::*;;
  logic core_clk = 0, rst = 1, master_reset_input = 0, irq3_out, irq3_oe_n, irq4_out, irq4_oe_n, l3, l4;
  logic [SPIRQ_PORTS-1:0][1:0] com_sel = '0;
  logic [SPIRQ_PORTS-1:0][SPIRQ_IER_W-1:0] interrupt_enable_reg = '0;
  logic [SPIRQ_PORTS-1:0][SPIRQ_MCR_W-1:0] modem_control_reg = '0;
  logic [SPIRQ_PORTS-1:0] rx_error = '0, rx_data_avail = '0, thr_empty = '0, modem_status_flag = '0;
  int miscompares = 0, checks_done = 0;
  always #5 core_clk = ~core_clk;
  spirq_out dut (.core_clk(core_clk), .rst(rst), .master_reset_input(master_reset_input), .com_sel(com_sel),
    .interrupt_enable_reg(interrupt_enable_reg), .modem_control_reg(modem_control_reg), .rx_error(rx_error),
    .rx_data_avail(rx_data_avail), .thr_empty(thr_empty), .modem_status_flag(modem_status_flag),
    .irq3_out(irq3_out), .irq3_oe_n(irq3_oe_n), .irq4_out(irq4_out), .irq4_oe_n(irq4_oe_n));
  spirq_host host (.irq3_out, .irq3_oe_n, .irq4_out, .irq4_oe_n, .irq3_line(l3), .irq4_line(l4));
  // inputs always move 1 ns after an edge, outputs are registered one edge later
  task step(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask
  task cmp(input string what, input logic exp, input logic got);
    checks_done++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED %s expected %b seen %b", what, exp, got);
    end
  endtask
  task test_route();
    modem_control_reg[0] = 5'h08;
    interrupt_enable_reg[0] = 4'h1;
    rx_data_avail[0] = 1;
    for (int c = 0; c < 4; c++) begin
      com_sel[0] = 2'(c);
      step(1);
      cmp("irq3", c[0], l3);
      cmp("irq4", !c[0], l4);
      cmp("irq4 enable", c[0], irq4_oe_n);
    end
    $display("test_route done");
  endtask
  task test_sources();
    // port 0 on com3 drives irq4, port 1 on com4 drives irq3; one port gated at a time
    com_sel = {SPIRQ_COM4, SPIRQ_COM3};
    for (int pt = 0; pt < SPIRQ_PORTS; pt++) begin
      modem_control_reg = '0;
      modem_control_reg[pt] = 5'h08;
      {modem_status_flag, rx_error, thr_empty, rx_data_avail} = '0;
      for (int s = 0; s < 4; s++) begin
        interrupt_enable_reg = '0;
        interrupt_enable_reg[pt] = 4'h1 << s;
        {modem_status_flag[pt], rx_error[pt], thr_empty[pt], rx_data_avail[pt]} = ~(4'h1 << s);
        step(1);
        cmp("line unenabled", 1'b0, pt ? l3 : l4);
        {modem_status_flag[pt], rx_error[pt], thr_empty[pt], rx_data_avail[pt]} = 4'h1 << s;
        step(1);
        cmp("line source", 1'b1, pt ? irq3_out : irq4_out);
      end
    end
    $display("test_sources done");
  endtask
  task test_clear();
    modem_status_flag[1] = 0;
    step(1);
    cmp("irq3 serviced", 1'b0, irq3_out);
    modem_status_flag[1] = 1;
    interrupt_enable_reg[1] = 4'h0;
    step(1);
    cmp("irq3 disabled", 1'b0, irq3_out);
    interrupt_enable_reg[1] = 4'h8;
    master_reset_input = 1;
    step(5);
    cmp("irq3 master reset", 1'b0, irq3_out);
    master_reset_input = 0;
    step(5);
    cmp("irq3 after master reset", 1'b1, irq3_out);
    modem_control_reg[1] = 5'h17;
    step(1);
    cmp("irq3 enable when gate clear", 1'b1, irq3_oe_n);
    cmp("irq3 line when gate clear", 1'b0, l3);
    $display("test_clear done");
  endtask
  task complete_run();
    $display("checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  initial begin
    step(12);
    rst = 0;
    test_route();
    test_sources();
    test_clear();
    complete_run();
  end
endmodule

// File: tb/spirq_host.sv
// host interrupt controller model for the two isa lines
`timescale 1ns/100ps
module spirq_host (
  // isa lines from the router
  input wire logic irq3_out,
  input wire logic irq3_oe_n,
  input wire logic irq4_out,
  input wire logic irq4_oe_n,
  // levels seen by the controller
  output logic irq3_line,
  output logic irq4_line
);
  // a released line sits on the board pull-down, so a float never reads as pending
  assign irq3_line = irq3_oe_n ? 1'b0 : irq3_out;
  assign irq4_line = irq4_oe_n ? 1'b0 : irq4_out;
endmodule
